// ---- logic/link_config_failsafe_map_regs.sv ----
// Link configuration and fail-safe output mapping register bank with APB access.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
`include "link_cfg_regs.svh"

module link_config_failsafe_map_regs #(
	parameter int unsigned TICK_CYCLES = `CLK_HZ / `US_HZ
) (
	// Clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    sys_rst_i,
	// Register bus
	input  wire link_cfg_pkg::apb_req_t  apb_req_i,
	output link_cfg_pkg::apb_rsp_t       apb_rsp_o,
	// Nonvolatile image
	input  wire link_cfg_pkg::nvm_image_t nvm_image_i,
	// Link events
	input  wire logic                    comm_valid_i,
	input  wire logic                    link_activity_i,
	input  wire logic                    failsafe_clear_i,
	// Output sources
	input  wire logic                    failsafe_input_zero_i,
	input  wire logic                    failsafe_input_one_i,
	input  wire logic [2:0]              normal_g_i,
	input  wire logic [2:0]              normal_h_i,
	input  wire logic [2:0]              address_strap_i,
	// Mapped outputs and status
	output logic [2:0]                   output_g_o,
	output logic [2:0]                   output_h_o,
	output logic                         failsafe_o,
	output logic                         acknowledge_enable_o,
	output logic [3:0]                   bus_address_o,
	output logic                         break_wait_expired_o
);
	import link_cfg_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic idx_hit(input logic [11:0] a, input logic [7:0] idx);
		return a == {2'b00, idx, 2'b00};
	endfunction : idx_hit

	function automatic logic [18:0] wd_limit_us(input logic [3:0] c);
		case (c)
			4'h1: return 19'(`WD_1_US);
			4'h2: return 19'(`WD_2_US);
			4'h3: return 19'(`WD_3_US);
			4'h4: return 19'(`WD_4_US);
			4'h5: return 19'(`WD_5_US);
			4'h6: return 19'(`WD_6_US);
			4'h7: return 19'(`WD_7_US);
			4'h8: return 19'(`WD_8_US);
			4'h9: return 19'(`WD_9_US);
			4'hA: return 19'(`WD_A_US);
			4'hB: return 19'(`WD_B_US);
			default: return 19'h00000;
		endcase
	endfunction : wd_limit_us

	function automatic logic [12:0] brk_limit_us(input logic [2:0] c);
		case (c)
			3'h0: return 13'(`BRK_0_US);
			3'h1: return 13'(`BRK_1_US);
			3'h2: return 13'(`BRK_2_US);
			3'h3: return 13'(`BRK_3_US);
			3'h4: return 13'(`BRK_4_US);
			3'h5: return 13'(`BRK_5_US);
			default: return 13'(`BRK_6_US);
		endcase
	endfunction : brk_limit_us

	function automatic logic pick(input logic sel, input logic zero, input logic one);
		return sel ? one : zero;
	endfunction : pick

	// ----------------------------------------
	// Register bus decode
	// ----------------------------------------
	logic        setup;
	logic        access;
	logic        wr_en;
	logic        hit_map;
	logic        hit_wd;
	logic        hit_addr;
	logic        mapped;
	logic [7:0]  map_q;
	logic [7:0]  wd_q;
	logic [7:0]  acfg_q;
	logic [7:0]  rd_d;
	logic [31:0] prdata_q;

	assign setup    = apb_req_i.psel & ~apb_req_i.penable;
	assign access   = apb_req_i.psel & apb_req_i.penable;
	assign hit_map  = idx_hit(apb_req_i.paddr, `MAP_GH_IDX);
	assign hit_wd   = idx_hit(apb_req_i.paddr, `WD_BRK_IDX);
	assign hit_addr = idx_hit(apb_req_i.paddr, `ADDR_CFG_IDX);
	assign mapped   = hit_map | hit_wd | hit_addr;
	assign wr_en    = access & apb_req_i.pwrite & mapped;

	assign apb_rsp_o.prdata  = prdata_q;
	assign apb_rsp_o.pready  = access;
	assign apb_rsp_o.pslverr = access & ~mapped;

	always_comb begin
		rd_d = 8'h00;
		if (hit_map) begin
			rd_d = map_q;
		end else if (hit_wd) begin
			rd_d = wd_q;
		end else if (hit_addr) begin
			rd_d = acfg_q;
		end
	end

	// Read data is captured in the setup cycle so it comes from a flop in the access cycle.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			prdata_q <= 32'h00000000;
		end else if (setup) begin
			prdata_q <= {24'h000000, rd_d};
		end
	end

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			map_q <= nvm_image_i.map_gh & `MAP_MASK; // R3 R11
		end else if (wr_en && hit_map) begin
			map_q <= apb_req_i.pwdata[7:0] & `MAP_MASK; // R11
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wd_q <= nvm_image_i.wd_brk_ack & `WD_BRK_MASK; // R3
		end else if (wr_en && hit_wd) begin
			wd_q <= apb_req_i.pwdata[7:0] & `WD_BRK_MASK;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			acfg_q <= nvm_image_i.addr_cfg & `ADDR_MASK; // R3 R11
		end else if (wr_en && hit_addr) begin
			acfg_q <= apb_req_i.pwdata[7:0] & `ADDR_MASK; // R11
		end
	end

	// ----------------------------------------
	// Microsecond tick
	// ----------------------------------------
	logic [15:0] tick_cnt_q;
	logic        tick;

	assign tick = tick_cnt_q == 16'(TICK_CYCLES - 1);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i || tick) begin
			tick_cnt_q <= 16'h0000;
		end else begin
			tick_cnt_q <= tick_cnt_q + 16'h0001;
		end
	end

	// ----------------------------------------
	// Communication watchdog
	// ----------------------------------------
	// Expiry waits one tick past the limit because the tick phase is free running,
	// so the timeout can be up to a microsecond late but never early.
	logic [3:0]  wd_code;
	logic [18:0] wd_limit;
	logic [19:0] wd_cnt_q;
	logic        wd_expired;
	logic        fs_set;
	safe_state_t safe_q;

	assign wd_code    = wd_q[`WD_MSB:`WD_LSB];
	assign wd_limit   = wd_limit_us(wd_code);
	assign wd_expired = wd_cnt_q > {1'b0, wd_limit};
	assign fs_set     = (wd_code >= 4'hC) || // R6
	                    (wd_code != 4'h0 && wd_code <= 4'hB && wd_expired); // R4 R5

	always_ff @(posedge clk_i) begin
		if (sys_rst_i || comm_valid_i) begin
			wd_cnt_q <= 20'h00000;
		end else if (tick && !wd_expired) begin
			wd_cnt_q <= wd_cnt_q + 20'h00001; // R5
		end
	end

	// A clear in the same cycle as a new entry condition loses, so no entry is dropped.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			safe_q <= SAFE_OFF;
		end else begin
			case (safe_q)
				SAFE_OFF: begin
					if (fs_set) begin
						safe_q <= SAFE_ON; // R5 R6
					end
				end
				SAFE_ON: begin
					if (failsafe_clear_i && !fs_set) begin
						safe_q <= SAFE_OFF;
					end
				end
				default: begin
					safe_q <= SAFE_OFF;
				end
			endcase
		end
	end

	assign failsafe_o = safe_q == SAFE_ON;

	// ----------------------------------------
	// Break waiting timer
	// ----------------------------------------
	logic [12:0] brk_limit;
	logic [13:0] brk_cnt_q;
	logic        brk_fire;
	logic        brk_pulse_q;

	assign brk_limit = brk_limit_us(wd_q[`BRK_MSB:`BRK_LSB]);
	assign brk_fire  = tick && brk_cnt_q == {1'b0, brk_limit} && !link_activity_i; // R7

	always_ff @(posedge clk_i) begin
		if (sys_rst_i || link_activity_i) begin
			brk_cnt_q <= 14'h0000;
		end else if (tick && brk_cnt_q <= {1'b0, brk_limit}) begin
			brk_cnt_q <= brk_cnt_q + 14'h0001; // R7
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			brk_pulse_q <= 1'b0;
		end else begin
			brk_pulse_q <= brk_fire;
		end
	end

	assign break_wait_expired_o = brk_pulse_q;

	// ----------------------------------------
	// Output mapping and link settings
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			output_g_o <= 3'h0;
			output_h_o <= 3'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				output_g_o[i] <= failsafe_o ?
					pick(map_q[i], failsafe_input_zero_i, failsafe_input_one_i) : normal_g_i[i]; // R2
				output_h_o[i] <= failsafe_o ?
					pick(map_q[`H_LSB + i], failsafe_input_zero_i, failsafe_input_one_i) : normal_h_i[i]; // R1
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			acknowledge_enable_o <= 1'b0;
			bus_address_o        <= 4'h0;
		end else begin
			acknowledge_enable_o <= wd_q[`ACK_BIT]; // R8
			bus_address_o        <= acfg_q[`ADDR_SRC_BIT] ? acfg_q[3:0] : {1'b0, address_strap_i}; // R9 R10
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_map_h_sel: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R1
		failsafe_o |=> output_h_o[2] == ($past(map_q[6]) ? $past(failsafe_input_one_i) : $past(failsafe_input_zero_i)))
		else $error("group H output not following its fail-safe input");
	chk_map_g_sel: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R2
		failsafe_o |=> output_g_o[0] == ($past(map_q[0]) ? $past(failsafe_input_one_i) : $past(failsafe_input_zero_i)))
		else $error("group G output not following its fail-safe input");
	chk_reset_load: assert property (@(posedge clk_i) // R3
		$past(sys_rst_i) |-> wd_q == $past(nvm_image_i.wd_brk_ack) && acfg_q == ($past(nvm_image_i.addr_cfg) & 8'h1F))
		else $error("reset did not load the nonvolatile image");
	chk_wd_disabled: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R4
		wd_code == 4'h0 |=> !$rose(failsafe_o))
		else $error("fail-safe entered with watchdog disabled");
	chk_wd_expiry: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R5
		$rose(failsafe_o) && $past(wd_code) inside {[4'h1:4'hB]} |-> $past(wd_cnt_q) > {1'b0, $past(wd_limit)})
		else $error("fail-safe entered before the watchdog limit");
	chk_wd_zero_time: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R6
		wd_code >= 4'hC |=> failsafe_o)
		else $error("zero timeout did not force fail-safe");
	chk_brk_window: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R7
		link_activity_i |=> !break_wait_expired_o [*2])
		else $error("break wait expired right after activity");
	chk_ack_write: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R8
		wr_en && hit_wd |=> ##1 acknowledge_enable_o == $past(apb_req_i.pwdata[0], 2))
		else $error("acknowledge enable not taken from write");
	chk_addr_source: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R9 R10
		!sys_rst_i |=> bus_address_o == ($past(acfg_q[4]) ? $past(acfg_q[3:0]) : {1'b0, $past(address_strap_i)}))
		else $error("bus address from wrong source");
	chk_reserved_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R11
		map_q[7] == 1'b0 && map_q[3] == 1'b0 && acfg_q[7:5] == 3'h0 && prdata_q[31:8] == 24'h000000)
		else $error("reserved bit not zero");
	chk_map_h_mid: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R1
		failsafe_o |=> output_h_o[1] == ($past(map_q[5]) ? $past(failsafe_input_one_i) : $past(failsafe_input_zero_i)))
		else $error("group H output 1 not following its fail-safe input");
	chk_map_h_low: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R1
		failsafe_o |=> output_h_o[0] == ($past(map_q[4]) ? $past(failsafe_input_one_i) : $past(failsafe_input_zero_i)))
		else $error("group H output 0 not following its fail-safe input");
	chk_map_g_mid: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R2
		failsafe_o |=> output_g_o[1] == ($past(map_q[1]) ? $past(failsafe_input_one_i) : $past(failsafe_input_zero_i)))
		else $error("group G output 1 not following its fail-safe input");
	chk_map_g_high: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R2
		failsafe_o |=> output_g_o[2] == ($past(map_q[2]) ? $past(failsafe_input_one_i) : $past(failsafe_input_zero_i)))
		else $error("group G output 2 not following its fail-safe input");
	chk_normal_pass: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R1 R2
		!sys_rst_i && !failsafe_o |=> output_g_o == $past(normal_g_i) && output_h_o == $past(normal_h_i))
		else $error("outputs not following normal sources outside fail-safe");
	chk_reset_map: assert property (@(posedge clk_i) // R3
		$past(sys_rst_i) |-> map_q == ($past(nvm_image_i.map_gh) & 8'h77))
		else $error("reset did not load the map from the nonvolatile image");
	chk_reset_safe: assert property (@(posedge clk_i) // R3
		$past(sys_rst_i) |-> !failsafe_o)
		else $error("fail-safe state not left by reset");
	chk_wd_restart: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R5
		!sys_rst_i && comm_valid_i |=> wd_cnt_q == 20'h00000)
		else $error("valid communication did not restart the watchdog");
	chk_brk_single: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R7
		break_wait_expired_o |=> !break_wait_expired_o)
		else $error("break wait pulse longer than one cycle");
	chk_brk_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R7
		$rose(break_wait_expired_o) |-> !$past(link_activity_i))
		else $error("break wait expired while the link was active");
	chk_ack_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R8
		!sys_rst_i |=> acknowledge_enable_o == $past(wd_q[0]))
		else $error("acknowledge enable not following its register bit");
	chk_unmapped_write: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R11
		!sys_rst_i && access && apb_req_i.pwrite && !mapped |=> $stable(map_q) && $stable(wd_q) && $stable(acfg_q))
		else $error("write to an unmapped address changed a register");
	chk_unmapped_read: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R11
		setup && !mapped |=> prdata_q == 32'h00000000)
		else $error("read of an unmapped address returned data");
endmodule : link_config_failsafe_map_regs

// ---- shared/link_cfg_regs.svh ----
// Constants for the link configuration and fail-safe map register bank.
//
// Behaviour
// R1 - Map bits 6:4 steer group-H outputs 2..0 to fail-safe input zero or one.
// R2 - Map bits 2:0 steer group-G outputs 2..0 to fail-safe input zero or one.
// R3 - At reset every writable field loads from the nonvolatile memory image.
// R4 - Watchdog code in bits 7:4; zero disables automatic fail-safe entry.
// R5 - Codes 1h..Bh time out 200us..500ms, then fail-safe is entered.
// R6 - Codes Ch..Fh mean zero timeout, fail-safe entered at once.
// R7 - Break wait code in bits 3:1 selects 1ms, 125us .. 5ms.
// R8 - Bit 0 of the first link register enables acknowledgements.
// R9 - Address source bit 4: zero uses strap pins, one uses internal field.
// R10 - Internal address bits 3:0 give the slave address equal to the code.
// R11 - Reserved bits read as zero and writes to them are ignored.
`ifndef LINK_CFG_REGS_SVH
`define LINK_CFG_REGS_SVH

// ----------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------
`define MAP_GH_IDX   8'h83
`define WD_BRK_IDX   8'h84
`define ADDR_CFG_IDX 8'h85

// ----------------------------------------
// Field positions and writable masks
// ----------------------------------------
`define MAP_MASK     8'h77
`define WD_BRK_MASK  8'hFF
`define ADDR_MASK    8'h1F
`define WD_MSB       7
`define WD_LSB       4
`define BRK_MSB      3
`define BRK_LSB      1
`define ACK_BIT      0
`define ADDR_SRC_BIT 4
`define H_LSB        4

// ----------------------------------------
// Timing in microseconds and clock rate
// ----------------------------------------
`define CLK_HZ       25000000
`define US_HZ        1000000
`define WD_1_US      200
`define WD_2_US      500
`define WD_3_US      1000
`define WD_4_US      2000
`define WD_5_US      5000
`define WD_6_US      10000
`define WD_7_US      20000
`define WD_8_US      50000
`define WD_9_US      100000
`define WD_A_US      200000
`define WD_B_US      500000
`define BRK_0_US     1000
`define BRK_1_US     125
`define BRK_2_US     250
`define BRK_3_US     500
`define BRK_4_US     1250
`define BRK_5_US     2500
`define BRK_6_US     5000

`endif

// ---- shared/link_cfg_pkg.sv ----
// Types shared by the link configuration register bank.
package link_cfg_pkg;
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic [7:0] map_gh;
		logic [7:0] wd_brk_ack;
		logic [7:0] addr_cfg;
	} nvm_image_t;

	typedef enum logic {
		SAFE_OFF = 1'b0,
		SAFE_ON  = 1'b1
	} safe_state_t;
endpackage : link_cfg_pkg

// ---- tb/link_host_model.sv ----
// Host side model that marks valid traffic and link activity.
`timescale 1ns/10ps
module link_host_model (
	// Clock and command
	input  wire logic clk_i,
	input  wire logic talk_i,
	// Link events
	output logic      comm_valid_o,
	output logic      link_activity_o
);
	// Traffic is seen one cycle after the host decides to talk, as a frame would be.
	always_ff @(posedge clk_i) begin
		comm_valid_o    <= talk_i;
		link_activity_o <= talk_i;
	end
endmodule : link_host_model

// ---- tb/testbench.sv ----
// Self-checking testbench for the link configuration register bank.
`timescale 1ns/10ps
module testbench;
	import link_cfg_pkg::*;
	logic       clk_i = 0, sys_rst_i = 1, talk = 1, fs_clr = 0, fs0 = 0, fs1 = 1;
	apb_req_t   req = '0;
	apb_rsp_t   rsp;
	nvm_image_t nvm = '{map_gh: 8'hFF, wd_brk_ack: 8'h03, addr_cfg: 8'hFA};
	logic       cv, la, fs, ack, brk;
	logic [2:0] og, oh;
	logic [3:0] ba;
	logic [31:0] rd;
	logic       er;
	int         miscompares = 0, num_checks = 0, fs_at, brk_at;
	link_host_model link_host_model_i (.clk_i(clk_i), .talk_i(talk), .comm_valid_o(cv), .link_activity_o(la));
	link_config_failsafe_map_regs #(.TICK_CYCLES(2)) link_config_failsafe_map_regs_i (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .apb_req_i(req), .apb_rsp_o(rsp), .nvm_image_i(nvm), .comm_valid_i(cv),
		.link_activity_i(la), .failsafe_clear_i(fs_clr), .failsafe_input_zero_i(fs0),
		.failsafe_input_one_i(fs1), .normal_g_i(3'h7), .normal_h_i(3'h7), .address_strap_i(3'h5),
		.output_g_o(og), .output_h_o(oh), .failsafe_o(fs), .acknowledge_enable_o(ack),
		.bus_address_o(ba), .break_wait_expired_o(brk));
	initial forever #20 clk_i = ~clk_i;
	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t %s got %0h expected %0h", $time, msg, got, exp);
		end
	endtask : chk
	// Waits for pready however long it takes; a hung slave is left to the watchdog.
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_i);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
		@(posedge clk_i);
		req.penable <= 1'b1;
		do begin
			@(posedge clk_i);
		end while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		er = rsp.pslverr;
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb
	task test_done;
		if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : test_done
	initial begin
		#200000;
		miscompares++;
		test_done();
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 0;
		repeat (2) @(posedge clk_i);
		apb(0, 12'h20C, 8'h00);
		chk(rd, 32'h77, "map reset");
		apb(0, 12'h210, 8'h00);
		chk(rd, 32'h03, "wd reset");
		apb(0, 12'h214, 8'h00);
		chk(rd, 32'h1A, "addr reset");
		chk({ack, ba}, 5'h1A, "ack and address");
		apb(0, 12'h218, 8'h00);
		chk(er, 32'h1, "unmapped read error");
		chk(rd, 32'h0, "unmapped read data");
		apb(1, 12'h218, 8'hFF);
		chk(er, 32'h1, "unmapped write error");
		apb(0, 12'h210, 8'h00);
		chk(rd, 32'h03, "unmapped write ignored");
		apb(1, 12'h20C, 8'h88);
		apb(0, 12'h20C, 8'h00);
		chk(rd, 32'h00, "reserved map");
		apb(1, 12'h214, 8'hEC);
		apb(0, 12'h214, 8'h00);
		chk(rd, 32'h0C, "reserved addr");
		@(posedge clk_i);
		chk(ba, 4'h5, "strap address");
		apb(1, 12'h214, 8'h1C);
		repeat (3) @(posedge clk_i);
		chk(ba, 4'hC, "internal address");
		apb(1, 12'h210, 8'h12);
		repeat (3) @(posedge clk_i);
		chk(ack, 1'b0, "ack off");
		repeat (500) @(posedge clk_i);
		chk(fs, 1'b0, "comm keeps alive");
		talk <= 0;
		fs_at = -1;
		brk_at = -1;
		// Watched on the falling edge so a one-cycle pulse is never raced against its launch.
		for (int i = 0; i < 420; i++) begin
			@(negedge clk_i);
			if (brk_at < 0 && brk === 1'b1) brk_at = i;
			if (fs_at < 0 && fs === 1'b1) fs_at = i;
		end
		chk(32'(fs_at >= 398 && fs_at <= 406), 32'h1, "watchdog 200us");
		chk(32'(brk_at >= 248 && brk_at <= 256), 32'h1, "break 125us");
		apb(1, 12'h20C, 8'h50);
		repeat (3) @(posedge clk_i);
		chk({oh, og}, 6'h28, "map h");
		apb(1, 12'h20C, 8'h05);
		repeat (3) @(posedge clk_i);
		chk({oh, og}, 6'h05, "map g");
		apb(1, 12'h210, 8'h02);
		talk <= 1;
		fs_clr <= 1;
		@(posedge clk_i);
		fs_clr <= 0;
		repeat (3) @(posedge clk_i);
		chk({fs, oh, og}, 7'h3F, "normal outputs");
		talk <= 0;
		repeat (800) @(posedge clk_i);
		chk(fs, 1'b0, "watchdog off");
		apb(1, 12'h210, 8'hC2);
		repeat (3) @(posedge clk_i);
		chk(fs, 1'b1, "zero timeout");
		nvm <= '{map_gh: 8'hC9, wd_brk_ack: 8'h0D, addr_cfg: 8'h2F};
		sys_rst_i <= 1;
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 0;
		repeat (2) @(posedge clk_i);
		chk({fs, oh, og}, 7'h3F, "outputs after reset");
		chk({ack, ba}, 5'h15, "ack and address after reset");
		apb(0, 12'h20C, 8'h00);
		chk(rd, 32'h41, "map reload");
		apb(0, 12'h210, 8'h00);
		chk(rd, 32'h0D, "wd reload");
		apb(0, 12'h214, 8'h00);
		chk(rd, 32'h0F, "addr reload");
		test_done();
	end
endmodule : testbench
